// ===== verilog/adc_host_pkg.sv
package adc_host_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int START_LOW_NS = 40;
  localparam int RD_LOW_NS = 40;
  localparam int RD_HIGH_NS = 40;
  localparam int ACQ_NS = 600;
  localparam int INT_PERIOD_NS = 200;
  localparam int START_REQUEST_N_PERIODS = 17;
  localparam int ACQ_PERIODS = 3;
  localparam int CYCLE_PERIODS = START_REQUEST_N_PERIODS + ACQ_PERIODS;
  // least times round up
  localparam int START_LOW_CYC = (START_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_LOW_CYC = (RD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_HIGH_CYC = (RD_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACQ_CYC = (ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // 1.5 internal periods after read strobe rises
  localparam int RD_TO_START_NS = (3 * INT_PERIOD_NS) / 2;
  localparam int RD_TO_START_CYC = (RD_TO_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // start request held high for the whole cycle plus margin
  localparam int START_REQUEST_N_NS = CYCLE_PERIODS * INT_PERIOD_NS;
  localparam int BUSY_WAIT_CYC = (START_REQUEST_N_NS * 2) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam logic [1:0] DIV_1 = 2'h0;
  localparam logic [1:0] DIV_8 = 2'h3;

  typedef enum logic [1:0] {
    RD_FULL,
    RD_BYTES
  } read_mode_type;

  // pins toward the converter
  typedef struct packed {
    logic chip_select_n;
    logic start_request_n;
    logic read_strobe_n;
    logic half_sel;
    logic channel_sel_hi;
    logic channel_sel_lo;
    logic divider_sel_hi;
    logic divider_sel_lo;
  } pins_out_type;
endpackage

// ===== verilog/adc_host_sync.sv
`timescale 1ns/10ps
// two-stage synchroniser for pin inputs
module adc_host_sync #(
  parameter int W = 1
) (
  input wire logic core_clk_i,   // core clock
  input wire logic rst_i,        // sync reset
  input wire logic [W-1:0] d_i,  // async input
  output logic [W-1:0] q_o       // synchronised
);
  logic [W-1:0] meta_q;
  // ---------------------------------------------------------------
  // stages
  // ---------------------------------------------------------------
  // first stage feeds only the second
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule

// ===== verilog/adc_host.sv
`timescale 1ns/10ps
// Converter rules this block works to
// R1: start by holding chip select and start request low together 40 ns.
// R2: device cycle is 20 internal periods: 17 convert, 3 acquire.
// R3: device converts from first internal clock edge after 40 ns request.
// R4: divider select codes 00,01,10,11 give ratios 1,2,4,8.
// R5: external clock must keep internal clock at or below 5 MHz.
// R6: busy rises within 70 ns of start, high until done.
// R7: result loads as busy falls; busy stays low until next start.
// R8: channel select captured on first rising strobe, used next conversion.
// R9: after 17 periods the device samples the previously captured channel.
// R10: wait at least 600 ns after conversion ends before next start.
// R11: raise start request and chip select 80 ns before second period edge.
// R12: start request stays high until the running conversion completes.
// R13: keep all control inputs stable from that point onward.
// R14: device drives data only while chip select and read strobe low.
// R15: read by holding chip select and read strobe low 40 ns.
// R16: next start no sooner than 1.5 periods after read strobe rises.
// R17: read strobe high at least 40 ns between two reads.
// R18: device floats data as busy rises regardless of read strobe.
// R19: read right after busy falls; release read strobe before start.
// R20: half select low presents full 16-bit result.
// R21: eight-line mode: low byte with half select low, high byte high.
// R22: results are two's complement.
// R23: channel select is an unsigned index 0 to 3.
// R24: result held until next conversion completes.
module adc_host (
  input wire logic core_clk_i,                  // 125 MHz clock
  input wire logic rst_i,                       // sync reset, high
  input wire logic cmd_valid_i,                 // request a conversion
  output logic cmd_ready_o,                     // idle, may accept
  input wire logic [1:0] cmd_channel_i,         // channel for next conversion
  input wire logic [1:0] cmd_divider_i,         // divider ratio code
  input wire logic cmd_bytes_i,                 // read over eight lines
  output logic res_valid_o,                     // result pulse
  output logic signed [15:0] res_data_o,        // two's complement result
  output logic timeout_o,                       // busy never rose or never fell, pulse
  output adc_host_pkg::pins_out_type pins_o,    // control pins
  input wire logic busy_i,                      // converter busy pin
  input wire logic [15:0] result_bus_i          // converter data pins
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_WAIT_BUSY,
    ST_CONVERT,
    ST_READ,
    ST_READ_GAP,
    ST_ACQ
  } state_type;

  state_type state_q;
  logic [adc_host_pkg::CNT_W-1:0] cnt_q;
  logic busy_s;
  logic [15:0] bus_s;
  logic bytes_q;
  logic hi_q;
  logic [7:0] lo_byte_q;
  logic [1:0] chan_q;
  logic [1:0] div_q;
  logic [adc_host_pkg::CNT_W-1:0] wait_q;

  // ---------------------------------------------------------------
  // pin input synchronisers
  // ---------------------------------------------------------------
  adc_host_sync #(.W(17)) u_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .d_i({busy_i, result_bus_i}),
    .q_o({busy_s, bus_s})
  );

  assign cmd_ready_o = (state_q == ST_IDLE);

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // the acquisition wait covers both 600 ns and 1.5 periods after read
  localparam int GAP_CYC = (adc_host_pkg::ACQ_CYC > adc_host_pkg::RD_TO_START_CYC) ?
    adc_host_pkg::ACQ_CYC : adc_host_pkg::RD_TO_START_CYC;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      wait_q <= '0;
      bytes_q <= 1'b0;
      hi_q <= 1'b0;
      chan_q <= 2'h0;
      div_q <= adc_host_pkg::DIV_8;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          cnt_q <= '0;
          if (cmd_valid_i) begin
            chan_q <= cmd_channel_i;                  // R23
            div_q <= cmd_divider_i;                   // R4
            bytes_q <= cmd_bytes_i;
            state_q <= ST_START;
          end
        end
        ST_START: begin
          // hold both low long enough to start
          if (cnt_q == adc_host_pkg::CNT_W'(adc_host_pkg::START_LOW_CYC - 1)) begin  // R1
            cnt_q <= '0;
            wait_q <= '0;
            state_q <= ST_WAIT_BUSY;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_WAIT_BUSY: begin
          // strobes already high: releases early, ahead of the 80 ns point
          wait_q <= wait_q + 1'b1;                    // R11
          if (busy_s) begin
            state_q <= ST_CONVERT;
          end else if (wait_q == adc_host_pkg::CNT_W'(adc_host_pkg::BUSY_WAIT_CYC)) begin
            state_q <= ST_IDLE;
          end
        end
        ST_CONVERT: begin
          // start request stays high, nothing toggles while busy
          wait_q <= wait_q + 1'b1;                    // R12 R13
          if (!busy_s) begin
            cnt_q <= '0;
            hi_q <= 1'b0;
            state_q <= ST_READ;                       // R19
          end else if (wait_q == adc_host_pkg::CNT_W'(adc_host_pkg::BUSY_WAIT_CYC)) begin
            state_q <= ST_IDLE;
          end
        end
        ST_READ: begin
          // strobe low 40 ns plus two sync stages before sampling
          if (cnt_q == adc_host_pkg::CNT_W'(adc_host_pkg::RD_LOW_CYC + 1)) begin  // R15
            cnt_q <= '0;
            if (bytes_q && !hi_q) begin
              state_q <= ST_READ_GAP;
            end else begin
              state_q <= ST_ACQ;
            end
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_READ_GAP: begin
          if (cnt_q == adc_host_pkg::CNT_W'(adc_host_pkg::RD_HIGH_CYC - 1)) begin  // R17
            cnt_q <= '0;
            hi_q <= 1'b1;                             // R21
            state_q <= ST_READ;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_ACQ: begin
          if (cnt_q == adc_host_pkg::CNT_W'(GAP_CYC - 1)) begin  // R10 R16
            cnt_q <= '0;
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // result capture
  // ---------------------------------------------------------------
  // sample at the end of the low window, just before strobe rises
  logic sample_now;
  assign sample_now = (state_q == ST_READ) &&
    (cnt_q == adc_host_pkg::CNT_W'(adc_host_pkg::RD_LOW_CYC + 1));
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      lo_byte_q <= 8'h00;
      res_data_o <= 16'sh0000;
      res_valid_o <= 1'b0;
    end else begin
      res_valid_o <= 1'b0;
      if (sample_now) begin
        if (!bytes_q) begin
          res_data_o <= $signed(bus_s);               // R20 R22
          res_valid_o <= 1'b1;
        end else if (!hi_q) begin
          lo_byte_q <= bus_s[7:0];
        end else begin
          res_data_o <= $signed({bus_s[7:0], lo_byte_q});  // R21
          res_valid_o <= 1'b1;
        end
      end
    end
  end

  // timeout pulse when busy never rose or never fell
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      timeout_o <= 1'b0;
    end else begin
      timeout_o <= (state_q == ST_WAIT_BUSY || state_q == ST_CONVERT) &&
        (wait_q == adc_host_pkg::CNT_W'(adc_host_pkg::BUSY_WAIT_CYC)) &&
        (state_q == ST_WAIT_BUSY ? !busy_s : busy_s);
    end
  end

  // ---------------------------------------------------------------
  // pin drive, all registered
  // ---------------------------------------------------------------
  // channel lines change as start falls, stable from there through the capturing rising edge
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pins_o <= '{chip_select_n: 1'b1, start_request_n: 1'b1, read_strobe_n: 1'b1,
                  half_sel: 1'b0, channel_sel_hi: 1'b0, channel_sel_lo: 1'b0,
                  divider_sel_hi: 1'b1, divider_sel_lo: 1'b1};
    end else begin
      pins_o.start_request_n <= !(state_q == ST_START);                      // R1
      pins_o.chip_select_n <= !(state_q == ST_START || state_q == ST_READ);  // R8 R14
      pins_o.read_strobe_n <= !(state_q == ST_READ);                         // R19
      pins_o.half_sel <= bytes_q && hi_q;                                    // R21
      pins_o.channel_sel_hi <= chan_q[1];                                    // R8
      pins_o.channel_sel_lo <= chan_q[0];
      pins_o.divider_sel_hi <= div_q[1];                                     // R4 R5
      pins_o.divider_sel_lo <= div_q[0];
    end
  end
endmodule

// ===== tb/adc_host_monitor.sv
`timescale 1ns/10ps
module adc_host_monitor (
  input wire logic core_clk_i, // core clock
  input wire logic rst_i, // sync reset
  input wire logic res_valid_o, // result pulse
  input wire logic signed [15:0] res_data_o, // result
  input wire adc_host_pkg::pins_out_type pins_o, // control pins
  input wire logic busy_i // converter busy
);
  default clocking mon_cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] quiet_q;
  // cycles since busy or read strobe; saturated so the first start is free
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      quiet_q <= 8'hff;
    end else if (busy_i || !pins_o.read_strobe_n) begin
      quiet_q <= 8'h00;
    end else if (quiet_q != 8'hff) begin
      quiet_q <= quiet_q + 8'h01;
    end
  end
  start_pulse_a: assert property ($fell(pins_o.start_request_n) |->
    (!pins_o.start_request_n && !pins_o.chip_select_n)[*5]
    ##1 (pins_o.start_request_n && pins_o.chip_select_n)) else $error("bad start pulse");
  read_low_a: assert property ($fell(pins_o.read_strobe_n) |->
    (!pins_o.read_strobe_n && !pins_o.chip_select_n)[*5]) else $error("short read");
  read_gap_a: assert property ($rose(pins_o.read_strobe_n) |->
    pins_o.read_strobe_n[*5]) else $error("short read gap");
  rd_idle_a: assert property ($fell(pins_o.start_request_n) |->
    pins_o.read_strobe_n) else $error("read low at start");
  acq_wait_a: assert property ($fell(pins_o.start_request_n) |->
    quiet_q >= 8'd75) else $error("start too soon");
  start_request_n_hold_a: assert property (busy_i && pins_o.start_request_n |=>
    pins_o.start_request_n) else $error("start during conversion");
  ctrl_steady_a: assert property (busy_i && $past(busy_i) |->
    $stable({pins_o.channel_sel_hi, pins_o.channel_sel_lo, pins_o.divider_sel_hi,
    pins_o.divider_sel_lo, pins_o.half_sel})) else $error("control moved");
  busy_read_a: assert property (!pins_o.read_strobe_n |-> !busy_i)
    else $error("read while busy");
  res_hold_a: assert property (!res_valid_o |-> $stable(res_data_o))
    else $error("result moved");
  res_pulse_a: assert property (res_valid_o |=> !res_valid_o)
    else $error("result pulse long");
endmodule
bind adc_host adc_host_monitor mon (.core_clk_i, .rst_i, .res_valid_o, .res_data_o, .pins_o,
  .busy_i);

// ===== tb/adc_dev_model.sv
`timescale 1ns/10ps
module adc_dev_model (
  input wire adc_host_pkg::pins_out_type pins_i, // control pins
  input wire logic mute_i, // ignore every start
  input wire logic slow_i, // late busy rise
  output logic busy_o, // conversion running
  output logic [15:0] result_bus_o // data pins
);
  logic [15:0] vals [4] = '{16'h8000, 16'h7fff, 16'hffff, 16'h0001};
  logic [15:0] res_q = 16'h0000;
  logic [1:0] cur = 2'h0;
  logic [1:0] nxt = 2'h0;
  logic ext_clk = 1'b0;
  logic int_clk = 1'b0;
  int ratio = 1;
  int cnt = 0;
  wire logic start_n = pins_i.chip_select_n | pins_i.start_request_n;
  wire logic rd_n = pins_i.chip_select_n | pins_i.read_strobe_n;
  // divider code decode; unknown codes fall back to 1
  always @(pins_i) begin
    case ({pins_i.divider_sel_hi, pins_i.divider_sel_lo})
      2'h1: ratio = 2;
      2'h2: ratio = 4;
      2'h3: ratio = 8;
      default: ratio = 1;
    endcase
  end
  // ext clock scaled so the divided clock never beats 200 ns
  always #(100.0 / ratio) ext_clk = ~ext_clk;
  // counting both edges keeps an even duty for every ratio
  always @(ext_clk) begin
    cnt++;
    if (cnt >= ratio) begin
      cnt = 0;
      int_clk = ~int_clk;
    end
  end
  // one conversion per start, on the channel latched at the start before
  initial begin
    busy_o = 1'b0;
    forever begin
      @(negedge start_n);
      if (!mute_i) begin
        #(slow_i ? 60 : 10) busy_o = 1'b1;
        // a late busy can come after the strobes are back high, so wait on the level
        wait (start_n === 1'b1);
        nxt = {pins_i.channel_sel_hi, pins_i.channel_sel_lo};
        @(posedge int_clk);
        repeat (17) @(posedge int_clk);
        res_q = vals[cur];
        busy_o = 1'b0;
        cur = nxt;
      end
    end
  end
  // released bus shows the inverse so a stale word never looks valid
  assign result_bus_o = (!rd_n && !busy_o) ?
    (pins_i.half_sel ? {res_q[7:0], res_q[15:8]} : res_q) : ~res_q;
endmodule

// ===== tb/adc_host_tb.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    err_total++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end
module adc_host_tb;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  logic [1:0] cmd_channel_i = 2'h0;
  logic [1:0] cmd_divider_i = 2'h0;
  logic cmd_bytes_i = 1'b0;
  logic mute = 1'b0;
  logic slow = 1'b0;
  logic cmd_ready_o, res_valid_o, timeout_o, busy_i;
  logic signed [15:0] res_data_o;
  logic [15:0] result_bus_i;
  adc_host_pkg::pins_out_type pins_o;
  logic [15:0] vals [4] = '{16'h8000, 16'h7fff, 16'hffff, 16'h0001};
  logic [1:0] lat = 2'h0;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  adc_host dut (.core_clk_i, .rst_i, .cmd_valid_i, .cmd_ready_o, .cmd_channel_i,
    .cmd_divider_i, .cmd_bytes_i, .res_valid_o, .res_data_o, .timeout_o, .pins_o, .busy_i,
    .result_bus_i);
  adc_dev_model dev (.pins_i(pins_o), .mute_i(mute), .slow_i(slow), .busy_o(busy_i),
    .result_bus_o(result_bus_i));
  task automatic print_verdict();
    if (err_total == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one command, then wait for the result or the timeout pulse
  task automatic run(input logic [1:0] c, input logic [1:0] d, input logic b);
    int n;
    @(negedge core_clk_i);
    {cmd_channel_i, cmd_divider_i, cmd_bytes_i, cmd_valid_i} = {c, d, b, 1'b1};
    while (cmd_ready_o !== 1'b1) @(negedge core_clk_i);
    @(negedge core_clk_i);
    cmd_valid_i = 1'b0;
    n = 0;
    while (res_valid_o !== 1'b1 && timeout_o !== 1'b1 && n < 2000) begin
      @(negedge core_clk_i);
      n++;
    end
  endtask
  // every channel and divider code; result is from the previous command's channel
  task automatic t_channels();
    for (int i = 0; i < 4; i++) begin
      run(2'(3 - i), 2'(i), 1'b0);
      `CHK(res_valid_o, 1'b1)
      `CHK(res_data_o, vals[lat])
      `CHK({pins_o.channel_sel_hi, pins_o.channel_sel_lo}, 2'(3 - i))
      `CHK({pins_o.divider_sel_hi, pins_o.divider_sel_lo}, 2'(i))
      lat = 2'(3 - i);
    end
  endtask
  // two-half read with a late busy rise
  task automatic t_bytes();
    slow = 1'b1;
    run(2'h2, 2'h3, 1'b1);
    `CHK(res_valid_o, 1'b1)
    `CHK(res_data_o, vals[lat])
    lat = 2'h2;
    slow = 1'b0;
  endtask
  // silent converter: timeout, old result kept, next start unaffected
  task automatic t_timeout();
    mute = 1'b1;
    run(2'h1, 2'h0, 1'b0);
    `CHK(timeout_o, 1'b1)
    // last result came from channel 0, read in two halves
    `CHK(res_data_o, vals[0])
    mute = 1'b0;
    run(2'h0, 2'h0, 1'b0);
    `CHK(res_valid_o, 1'b1)
    `CHK(res_data_o, vals[lat])
  endtask
  always #4 core_clk_i = ~core_clk_i;
  // watchdog well above the roughly 4200 cycles the run needs
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 12000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    repeat (4) @(posedge core_clk_i);
    @(negedge core_clk_i);
    rst_i = 1'b0;
    t_channels();
    t_bytes();
    t_timeout();
    print_verdict();
  end
endmodule
